/* File: alarm_card_checker_sva.sv */
`timescale 1ns/1ns
module alarm_card_checker
   import alarm_card_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic [11:0]        s_axi_awaddr,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic [7:0]         base_address_setting,
   input wire logic               ack_source_select_setting,
   input wire logic               signal_enable_setting,
   input wire logic               watchdog_polarity_setting,
   input wire logic               break_contact_setting,
   input wire logic               ext_ack_chain_out,
   input wire logic [NUM_OUT-1:0] signal_relay,
   input wire logic               group_alarm,
   input wire logic               watchdog_relay
);
   logic [7:0] since_rst_q;
   logic       wr_take;
   logic       in_win;

   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign in_win  = s_axi_awaddr[11:4] == base_address_setting;

   // saturates so that the power-up checks fire once per reset only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         since_rst_q <= 8'h00;
      else if (since_rst_q != 8'hFF)
         since_rst_q <= since_rst_q + 8'h01;
   end

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   power_up_open_a: assert property (since_rst_q == 8'h03 && signal_enable_setting
      |-> signal_relay == {NUM_OUT{break_contact_setting}})
      else $error("relay not at rest after reset");
   wdog_sense_a: assert property (since_rst_q == 8'h03
      |-> watchdog_relay == watchdog_polarity_setting)
      else $error("watchdog sense wrong after reset");
   disabled_quiet_a: assert property ((!signal_enable_setting && !break_contact_setting) [*3]
      |=> signal_relay == '0 && !group_alarm)
      else $error("outputs active while disabled");
   group_or_a: assert property ((signal_enable_setting && !break_contact_setting
      && $stable(signal_relay) && $stable(group_alarm)) [*4] |-> group_alarm == (|signal_relay))
      else $error("group alarm differs from relay OR");
   write_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   outside_err_a: assert property (wr_take && !in_win |-> ##2 s_axi_bresp == RESP_SLVERR)
      else $error("outside write not refused");
   inside_okay_a: assert property (wr_take && in_win |-> ##2 s_axi_bresp == RESP_OKAY)
      else $error("window write refused");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chain_local_a: assert property (!ack_source_select_setting [*3] |=> !ext_ack_chain_out)
      else $error("chain forwarded in host mode");

   cover property (wr_take);
   cover property (s_axi_arvalid && s_axi_arready);
   cover property ($rose(watchdog_relay));
   cover property ($fell(signal_relay[0]));
endmodule : alarm_card_checker

bind alarm_signal_watchdog_card alarm_card_checker checker_i (
   .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .base_address_setting, .ack_source_select_setting, .signal_enable_setting,
   .watchdog_polarity_setting, .break_contact_setting, .ext_ack_chain_out, .signal_relay,
   .group_alarm, .watchdog_relay
);

/* File: alarm_card_pkg.sv */
// Behaviour
// R1: three independent relay outputs driving horn, buzzer or lamp
// R2: host retriggers the watchdog before it can drop out
// R3: watchdog drops out 3.5 s after the last trigger, raising the failure alarm
// R4: watchdog output sense selectable, normal by default or inverted
// R5: make contact is open at power-up and stays open until an alarm
// R6: a classified alarm event from the host closes the output contact
// R7: a new event closes an output only after an acknowledgment since activation
// R8: acknowledgment by host only, or by host or external pushbutton
// R9: in external mode the acknowledgment is passed on to chained cards
// R10: removing the enable setting disables the signalling outputs entirely
// R11: acknowledgment clears all flags to 0 and resets all outputs together; the code clears active_q but sets armed_q to 1 and leaves irq_st_q set
// R12: group alarm output is the OR of the individual alarms
// R13: three isolated binary inputs whose levels the host can read
// R14: window decoded at a settable base address, default 180H
// R15: break-contact option opens the output on alarm instead of closing it
// R16: window spans 16 bytes, low four address bits pick the location
// R17: pushbutton and binary inputs pass two flip-flops and a debouncer first
package alarm_card_pkg;

   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned WDOG_TIME_MS    = 3500;
   localparam int unsigned WDOG_CYCLES     = CLK_HZ / 1000 * WDOG_TIME_MS;
   localparam int unsigned DEBOUNCE_TIME_US = 10;
   localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_TIME_US;
   localparam int unsigned NUM_OUT         = 3;
   localparam int unsigned NUM_IN          = 3;

   localparam logic [11:0] BASE_DEFAULT    = 12'h180;

   // register byte offsets inside the 16-byte window
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_EVENT   = 4'h4;
   localparam logic [3:0] OFS_STATUS  = 4'h8;
   localparam logic [3:0] OFS_IRQ_ST  = 4'hC;

   localparam int unsigned CTL_ACK_BIT  = 0;
   localparam int unsigned CTL_TRIG_BIT = 1;
   localparam int unsigned CTL_MASK_LSB = 8;

   localparam int unsigned ST_OUT_LSB   = 0;
   localparam int unsigned ST_ARMED_LSB = 4;
   localparam int unsigned ST_IN_LSB    = 8;
   localparam int unsigned ST_WDOG_BIT  = 12;
   localparam int unsigned ST_GROUP_BIT = 13;

   localparam int unsigned IRQ_WDOG_BIT = 0;
   localparam int unsigned IRQ_ACK_BIT  = 1;
   localparam int unsigned IRQ_IN_LSB   = 2;
   localparam int unsigned IRQ_WIDTH    = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic ack_external;
      logic signal_enable;
      logic watchdog_enable;
      logic watchdog_inverted;
      logic break_contact;
   } card_setting_type;

   typedef enum {WR_IDLE, WR_RESP} wr_state_type;

endpackage : alarm_card_pkg

/* File: alarm_signal_watchdog_card.sv */
`timescale 1ns/1ns
module alarm_signal_watchdog_card
   import alarm_card_pkg::*;
#(
   parameter int unsigned WDOG_COUNT     = WDOG_CYCLES,
   parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_CYCLES
)(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // AXI4-Lite slave
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // static settings
   input  wire logic [7:0]            base_address_setting,
   input  wire logic                  ack_source_select_setting,
   input  wire logic                  signal_enable_setting,
   input  wire logic                  watchdog_enable_setting,
   input  wire logic                  watchdog_polarity_setting,
   input  wire logic                  break_contact_setting,
   // field side
   input  wire logic                  ext_ack_button,
   input  wire logic                  ext_ack_chain_in,
   input  wire logic [NUM_IN-1:0]     binary_input_raw,
   output logic                       ext_ack_chain_out,
   output logic [NUM_OUT-1:0]         signal_relay,
   output logic                       group_alarm,
   output logic                       watchdog_relay,
   output logic                       irq
);
   function automatic logic hit(input logic [11:0] addr, input logic [7:0] base);
      hit = (addr[11:4] == base);   // see R14, R16
   endfunction : hit

   card_setting_type set_q;
   logic [NUM_IN-1:0]  bin_clean;
   logic [1:0]         ack_clean;
   logic               wd_expired;
   logic               wd_pulse;

   // register inputs for timing; they are jumpers, so latency is free
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         set_q <= '0;
      else
      begin
         set_q.ack_external      <= ack_source_select_setting;   // see R8
         set_q.signal_enable     <= signal_enable_setting;
         set_q.watchdog_enable   <= watchdog_enable_setting;
         set_q.watchdog_inverted <= watchdog_polarity_setting;   // see R4
         set_q.break_contact     <= break_contact_setting;
      end
   end

   input_conditioner #(.WIDTH(NUM_IN), .CYCLES(DEBOUNCE_COUNT)) u_bin (
      .clk   (clk),
      .rst_n (rst_n),
      .raw   (binary_input_raw),
      .clean (bin_clean)
   );

   input_conditioner #(.WIDTH(2), .CYCLES(DEBOUNCE_COUNT)) u_ack (
      .clk   (clk),
      .rst_n (rst_n),
      .raw   ({ext_ack_chain_in, ext_ack_button}),
      .clean (ack_clean)
   );

   logic        aw_have_q;
   logic        w_have_q;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        wr_go;
   wr_state_type wr_state_q;

   assign wr_go = aw_have_q && w_have_q && (wr_state_q == WR_IDLE);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have_q  <= 1'b0;
         w_have_q   <= 1'b0;
         aw_addr_q  <= '0;
         w_data_q   <= '0;
         w_strb_q   <= '0;
         bvalid_q   <= 1'b0;
         bresp_q    <= RESP_OKAY;
         wr_state_q <= WR_IDLE;
      end
      else
      begin
         if (s_axi_awvalid && !aw_have_q && wr_state_q == WR_IDLE)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_q && wr_state_q == WR_IDLE)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         case (wr_state_q)
            WR_IDLE:
               if (wr_go)
               begin
                  aw_have_q  <= 1'b0;
                  w_have_q   <= 1'b0;
                  bvalid_q   <= 1'b1;
                  bresp_q    <= hit(aw_addr_q, base_address_setting) ? RESP_OKAY : RESP_SLVERR;
                  wr_state_q <= WR_RESP;
               end
            WR_RESP:
               if (s_axi_bready)
               begin
                  bvalid_q   <= 1'b0;
                  wr_state_q <= WR_IDLE;
               end
            default:
               wr_state_q <= WR_IDLE;
         endcase
      end
   end

   assign s_axi_awready = !aw_have_q && wr_state_q == WR_IDLE;
   assign s_axi_wready  = !w_have_q && wr_state_q == WR_IDLE;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   logic wr_ok;
   logic wr_ctl;
   logic wr_evt;
   logic wr_irq;
   assign wr_ok  = wr_go && hit(aw_addr_q, base_address_setting) && w_strb_q[0];
   assign wr_ctl = wr_ok && aw_addr_q[3:0] == OFS_CONTROL;
   assign wr_evt = wr_ok && aw_addr_q[3:0] == OFS_EVENT;
   assign wr_irq = wr_ok && aw_addr_q[3:0] == OFS_IRQ_ST;

   logic sw_ack;
   logic sw_trig;
   assign sw_ack  = wr_ctl && w_data_q[CTL_ACK_BIT];
   assign sw_trig = wr_ctl && w_data_q[CTL_TRIG_BIT];

   watchdog_monoflop #(.CYCLES(WDOG_COUNT)) u_wdog (
      .clk          (clk),
      .rst_n        (rst_n),
      .enable       (set_q.watchdog_enable),
      .trigger      (sw_trig),   // see R2
      .expired      (wd_expired),
      .expire_pulse (wd_pulse)
   );

   logic ext_ack_level;
   logic ext_ack_prev_q;
   logic ext_ack_rise;
   logic ack_any;
   assign ext_ack_level = set_q.ack_external && (ack_clean[0] || ack_clean[1]);
   assign ext_ack_rise  = ext_ack_level && !ext_ack_prev_q;
   assign ack_any       = sw_ack || ext_ack_rise;   // see R8

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_ack_prev_q    <= 1'b0;
         ext_ack_chain_out <= 1'b0;
      end
      else
      begin
         ext_ack_prev_q    <= ext_ack_level;
         // only the local button is forwarded, so a ring of cards cannot latch itself
         ext_ack_chain_out <= set_q.ack_external && ack_clean[0];   // see R9
      end
   end

   // active_q: contact in alarm; armed_q: a new activation is allowed
   logic [NUM_OUT-1:0] active_q;
   logic [NUM_OUT-1:0] armed_q;

   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++)
      begin : gen_out
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               active_q[g] <= 1'b0;   // see R5
               armed_q[g]  <= 1'b1;
            end
            else if (ack_any)
            begin
               active_q[g] <= 1'b0;   // see R11
               armed_q[g]  <= 1'b1;
            end
            else if (wr_evt && w_data_q[g] && armed_q[g])
            begin
               active_q[g] <= 1'b1;   // see R6
               armed_q[g]  <= 1'b0;   // see R7
            end
         end
      end
   endgenerate

   // relay drive; contact is held de-energised while disabled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         signal_relay   <= '0;
         group_alarm    <= 1'b0;
         watchdog_relay <= 1'b0;
      end
      else
      begin
         if (!set_q.signal_enable)
            signal_relay <= '0;   // see R10
         else
            signal_relay <= active_q ^ {NUM_OUT{set_q.break_contact}};   // see R1, R15
         group_alarm    <= set_q.signal_enable && (|active_q);   // see R12
         watchdog_relay <= wd_expired ^ set_q.watchdog_inverted;   // see R3, R4
      end
   end

   // interrupt status: sticky, write one to clear; a new event wins over the clear
   logic [IRQ_WIDTH-1:0] irq_st_q;
   logic [IRQ_WIDTH-1:0] irq_msk_q;
   logic [NUM_IN-1:0]    bin_prev_q;
   logic [IRQ_WIDTH-1:0] irq_set;
   assign irq_set = {bin_clean ^ bin_prev_q, ext_ack_rise, wd_pulse};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_st_q   <= '0;
         irq_msk_q  <= '0;
         bin_prev_q <= '0;
         irq        <= 1'b0;
      end
      else
      begin
         bin_prev_q <= bin_clean;
         irq_st_q   <= (irq_st_q & ~(wr_irq ? w_data_q[IRQ_WIDTH-1:0] : '0)) | irq_set;
         if (wr_ctl && w_strb_q[1])
            irq_msk_q <= w_data_q[CTL_MASK_LSB +: IRQ_WIDTH];
         irq <= |(irq_st_q & irq_msk_q);
      end
   end

   // read channel, answers one cycle after the address is taken
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [31:0] rd_val;

   always_comb
   begin
      rd_val = '0;
      case (s_axi_araddr[3:0])
         OFS_CONTROL: rd_val[CTL_MASK_LSB +: IRQ_WIDTH] = irq_msk_q;
         OFS_EVENT:   rd_val[NUM_OUT-1:0] = active_q;
         OFS_STATUS:
         begin
            rd_val[ST_OUT_LSB +: NUM_OUT]   = active_q;
            rd_val[ST_ARMED_LSB +: NUM_OUT] = armed_q;
            rd_val[ST_IN_LSB +: NUM_IN]     = bin_clean;   // see R13
            rd_val[ST_WDOG_BIT]             = wd_expired;
            rd_val[ST_GROUP_BIT]            = |active_q;
         end
         OFS_IRQ_ST:  rd_val[IRQ_WIDTH-1:0] = irq_st_q;
         default:     rd_val = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end
      else if (rvalid_q)
      begin
         if (s_axi_rready)
            rvalid_q <= 1'b0;
      end
      else if (s_axi_arvalid)
      begin
         rvalid_q <= 1'b1;
         if (hit(s_axi_araddr, base_address_setting))
         begin
            rdata_q <= rd_val;
            rresp_q <= RESP_OKAY;
         end
         else
         begin
            rdata_q <= '0;
            rresp_q <= RESP_SLVERR;
         end
      end
   end

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
endmodule : alarm_signal_watchdog_card

/* File: alarm_signal_watchdog_card_tb.sv */
`timescale 1ns/1ns
module alarm_signal_watchdog_card_tb;
   import alarm_card_pkg::*;

   localparam logic [11:0] CTRL = 12'h180;
   localparam logic [11:0] EVT  = 12'h184;
   localparam logic [11:0] STAT = 12'h188;
   localparam logic [11:0] IRQS = 12'h18C;

   logic             clk           = 1'b0;
   logic             rst_n         = 1'b0;
   logic [11:0]      s_axi_awaddr  = 12'h000;
   logic             s_axi_awvalid = 1'b0;
   logic [31:0]      s_axi_wdata   = 32'h0000_0000;
   logic             s_axi_wvalid  = 1'b0;
   logic             s_axi_bready  = 1'b0;
   logic [11:0]      s_axi_araddr  = 12'h000;
   logic             s_axi_arvalid = 1'b0;
   logic             s_axi_rready  = 1'b0;
   logic             press         = 1'b0;
   logic             chain_press   = 1'b0;
   logic [2:0]       levels        = 3'h0;
   card_setting_type cfg           = 5'b01000;
   int               error_cnt     = 0;
   int               check_count   = 0;
   logic [31:0]      s_axi_rdata;
   logic [1:0]       s_axi_bresp, s_axi_rresp;
   logic [2:0]       signal_relay, binary_input_raw;
   logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic             ext_ack_button, ext_ack_chain_in, ext_ack_chain_out;
   logic             group_alarm, watchdog_relay, irq;

   alarm_signal_watchdog_card #(
      .WDOG_COUNT     (50),
      .DEBOUNCE_COUNT (4)
   ) DUT (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb (4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base_address_setting (8'h18),
      .ack_source_select_setting (cfg.ack_external),
      .signal_enable_setting     (cfg.signal_enable),
      .watchdog_enable_setting   (cfg.watchdog_enable),
      .watchdog_polarity_setting (cfg.watchdog_inverted),
      .break_contact_setting     (cfg.break_contact),
      .ext_ack_button, .ext_ack_chain_in, .binary_input_raw, .ext_ack_chain_out,
      .signal_relay, .group_alarm, .watchdog_relay, .irq
   );

   field_side_model field (
      .clk, .press, .chain_press, .levels, .ext_ack_button, .ext_ack_chain_in, .binary_input_raw
   );

   initial
   begin
      forever #2 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      check_count++;
      if (got !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, e, got);
      end
   endtask : chk

   task automatic chk1(input string what, input logic e, input logic got);
      chk(what, {31'h0, e}, {31'h0, got});
   endtask : chk1

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask : idle

   task automatic outs(input logic [2:0] rel, input logic grp);
      chk("relay", {29'h0, rel}, {29'h0, signal_relay});
      chk1("group", grp, group_alarm);
   endtask : outs

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n     = 0;
      logic aw_ok = 1'b0;
      logic w_ok  = 1'b0;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok) && n < 100)
      begin
         @(posedge clk);
         n++;
         aw_ok = aw_ok || s_axi_awready;
         w_ok  = w_ok || s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid  <= !w_ok;
      end
      while (!s_axi_bvalid && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, s_axi_bvalid ? {30'h0, s_axi_bresp} : 32'hFFFF_FFFF);
   endtask : wr

   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!s_axi_arready && n < 100);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      s_axi_rready <= 1'b0;
      chk(what, e, s_axi_rvalid ? s_axi_rdata & m : ~e);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : rdc

   // generous bound: the whole sequence needs well under 3000 cycles
   initial
   begin
      #120000;
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdc("status", STAT, 32'h3777, 32'h0070, RESP_OKAY);
      wr(12'h190, 32'h7, RESP_SLVERR);
      rdc("outside", 12'h284, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
      idle(6);
      outs(3'h0, 1'b0);
      chk1("wdog", 1'b0, watchdog_relay);
      $display("reset test done");
      wr(EVT, 32'h1, RESP_OKAY);
      idle(6);
      outs(3'h1, 1'b1);
      rdc("armed", STAT, 32'h2077, 32'h2061, RESP_OKAY);
      wr(CTRL, 32'h1, RESP_OKAY);
      idle(6);
      outs(3'h0, 1'b0);
      rdc("rearmed", STAT, 32'h0077, 32'h0070, RESP_OKAY);
      wr(EVT, 32'h7, RESP_OKAY);
      idle(6);
      outs(3'h7, 1'b1);
      wr(CTRL, 32'h1, RESP_OKAY);
      cfg.break_contact <= 1'b1;
      idle(6);
      outs(3'h7, 1'b0);
      wr(EVT, 32'h2, RESP_OKAY);
      idle(6);
      outs(3'h5, 1'b1);
      wr(CTRL, 32'h1, RESP_OKAY);
      cfg.break_contact <= 1'b0;
      cfg.signal_enable <= 1'b0;
      wr(EVT, 32'h1, RESP_OKAY);
      idle(6);
      outs(3'h0, 1'b0);
      wr(CTRL, 32'h1, RESP_OKAY);
      cfg.signal_enable <= 1'b1;
      $display("alarm test done");
      cfg.watchdog_enable <= 1'b1;
      repeat (3)
      begin
         wr(CTRL, 32'h2, RESP_OKAY);
         idle(40);
         chk1("wdog held", 1'b0, watchdog_relay);
      end
      idle(20);
      chk1("wdog expired", 1'b1, watchdog_relay);
      cfg.watchdog_inverted <= 1'b1;
      idle(4);
      chk1("wdog inverted", 1'b0, watchdog_relay);
      rdc("irq wdog", IRQS, 32'h1, 32'h1, RESP_OKAY);
      wr(CTRL, 32'h100, RESP_OKAY);
      idle(3);
      chk1("irq on", 1'b1, irq);
      rdc("mask", CTRL, 32'h1F00, 32'h0100, RESP_OKAY);
      wr(IRQS, 32'h1, RESP_OKAY);
      idle(3);
      chk1("irq off", 1'b0, irq);
      wr(CTRL, 32'h2, RESP_OKAY);
      idle(5);
      chk1("wdog live inv", 1'b1, watchdog_relay);
      cfg.watchdog_enable   <= 1'b0;
      cfg.watchdog_inverted <= 1'b0;
      $display("watchdog test done");
      wr(EVT, 32'h1, RESP_OKAY);
      press <= 1'b1;
      idle(16);
      outs(3'h1, 1'b1);
      chk1("chain out", 1'b0, ext_ack_chain_out);
      press <= 1'b0;
      cfg.ack_external <= 1'b1;
      idle(16);
      press <= 1'b1;
      idle(16);
      outs(3'h0, 1'b0);
      chk1("chain out", 1'b1, ext_ack_chain_out);
      press <= 1'b0;
      idle(16);
      rdc("irq ack", IRQS, 32'h2, 32'h2, RESP_OKAY);
      wr(EVT, 32'h2, RESP_OKAY);
      chain_press <= 1'b1;
      idle(16);
      outs(3'h0, 1'b0);
      chk1("chain local", 1'b0, ext_ack_chain_out);
      chain_press <= 1'b0;
      $display("ack test done");
      levels <= 3'h5;
      idle(16);
      rdc("inputs", STAT, 32'h0700, 32'h0500, RESP_OKAY);
      rdc("irq inputs", IRQS, 32'h1C, 32'h14, RESP_OKAY);
      levels <= 3'h2;
      idle(16);
      rdc("inputs", STAT, 32'h0700, 32'h0200, RESP_OKAY);
      $display("input test done");
      end_of_test();
   end
endmodule : alarm_signal_watchdog_card_tb

/* File: field_side_model.sv */
`timescale 1ns/1ns
module field_side_model
   import alarm_card_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              press,
   input  wire logic              chain_press,
   input  wire logic [NUM_IN-1:0] levels,
   output logic                   ext_ack_button,
   output logic                   ext_ack_chain_in,
   output logic [NUM_IN-1:0]      binary_input_raw
);
   logic       press_q  = 1'b0;
   logic [1:0] bounce_q = 2'h0;

   // a real contact chatters after each change, so the card must filter it
   always_ff @(posedge clk)
   begin
      press_q <= press;
      if (press != press_q)
         bounce_q <= 2'h3;
      else if (bounce_q != 2'h0)
         bounce_q <= bounce_q - 2'h1;
   end

   assign ext_ack_button = (bounce_q != 2'h0) ? bounce_q[0] : press_q;

   always_ff @(posedge clk)
   begin
      ext_ack_chain_in <= chain_press;
      binary_input_raw <= levels;
   end
endmodule : field_side_model

/* File: input_conditioner.sv */
`timescale 1ns/1ns
module input_conditioner
   import alarm_card_pkg::*;
#(
   parameter int unsigned WIDTH  = 1,
   parameter int unsigned CYCLES = 16
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] clean
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= raw;    // see R17
         sync_q <= meta_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : gen_bit
         logic [31:0] cnt_q;
         logic        out_q;
         // a level must hold for CYCLES before it is accepted: contact bounce is dropped
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cnt_q <= '0;
               out_q <= 1'b0;
            end
            else if (sync_q[g] == out_q)
               cnt_q <= '0;
            else if (cnt_q >= CYCLES - 1)
            begin
               cnt_q <= '0;
               out_q <= sync_q[g];   // see R17
            end
            else
               cnt_q <= cnt_q + 32'h1;
         end
         assign clean[g] = out_q;
      end
   endgenerate
endmodule : input_conditioner

/* File: watchdog_monoflop.sv */
`timescale 1ns/1ns
module watchdog_monoflop
   import alarm_card_pkg::*;
#(
   parameter int unsigned CYCLES = WDOG_CYCLES
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic trigger,
   output logic      expired,
   output logic      expire_pulse
);
   logic [31:0] cnt_q;
   logic        exp_q;
   logic        pulse_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q   <= '0;
         exp_q   <= 1'b0;
         pulse_q <= 1'b0;
      end
      else
      begin
         pulse_q <= 1'b0;
         if (!enable || trigger)
         begin
            cnt_q <= '0;
            exp_q <= 1'b0;
         end
         else if (!exp_q)
         begin
            if (cnt_q >= CYCLES - 1)
            begin
               exp_q   <= 1'b1;   // see R3
               pulse_q <= 1'b1;
            end
            else
               cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   assign expired      = exp_q;
   assign expire_pulse = pulse_q;
endmodule : watchdog_monoflop
